// ### hdl/pems_pkg.sv
// Purpose: shared constants and types for the link error mask and severity bank
// Assumes: one 20 MHz clock, link core events arrive on that clock
// Notes: offsets are configuration space byte addresses
package pems_pkg;
	// register offsets
	localparam logic [11:0] UNC_MASK_OFS = 12'h108;
	localparam logic [11:0] UNC_SEV_OFS = 12'h10c;
	localparam logic [11:0] COR_STS_OFS = 12'h110;
	localparam logic [11:0] COR_MSK_OFS = 12'h114;
	// implemented bit positions; everything else reads zero
	localparam logic [31:0] UNC_IMPL_BITS = 32'h0017f010;
	localparam logic [31:0] COR_IMPL_BITS = 32'h000011c1;
	// reset values
	localparam logic [31:0] UNC_MASK_RESET = 32'h00000000;
	localparam logic [31:0] UNC_SEV_RESET = 32'h00030010;
	localparam logic [31:0] COR_STS_RESET = 32'h00000000;
	localparam logic [31:0] COR_MSK_RESET = 32'h00000000;
	localparam logic [4:0] FEP_RESET = 5'h00;
	// correctable field positions
	localparam int COR_REPLAY_TIMEOUT_BIT = 12;
	localparam int COR_REPLAY_WRAP_BIT = 8;
	localparam int COR_BAD_LINK_BIT = 7;
	localparam int COR_BAD_TRANS_BIT = 6;
	localparam int COR_RECEIVER_BIT = 0;
	// replay counter wrap points
	localparam logic [1:0] REPLAY_NUM_LAST = 2'h3;
	localparam logic [1:0] REPLAY_NUM_FIRST = 2'h0;
	// message codes toward the host bridge
	typedef enum logic [1:0] {PEMS_MSG_COR = 2'b00, PEMS_MSG_NONFATAL = 2'b01,
		PEMS_MSG_FATAL = 2'b11} pems_msg_t;
	typedef enum logic {PEMS_TX_IDLE = 1'b0, PEMS_TX_SEND = 1'b1} pems_tx_t;
	typedef enum logic {PEMS_LOG_ARMED = 1'b0, PEMS_LOG_LOCKED = 1'b1} pems_log_t;

	// byte enables widened to a bit mask
	function automatic logic [31:0] pems_lane_mask(input logic [3:0] be);
		pems_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : pems_lane_mask

	// index of the lowest set bit, zero when none
	function automatic logic [4:0] pems_first_bit(input logic [31:0] v);
		pems_first_bit = 5'h00;
		for (int i = 31; i >= 0; i--)
			if (v[i])
				pems_first_bit = i[4:0];
	endfunction : pems_first_bit
endpackage : pems_pkg

// ### hdl/pems_first_err.sv
// Purpose: first error pointer and header log lock for unmasked uncorrectable errors
// Assumes: status is the uncorrectable status vector, same clock
// Notes: pointer and lock are sticky, untouched by link reset; the lock also frees when the pointed status bit clears
`timescale 1ns/10ps
module pems_first_err
	import pems_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [31:0] evt,
	input wire logic [31:0] status,
	output logic [4:0] first_error_pointer,
	output logic hdr_capture
);
	pems_log_t log_state;
	logic pointed_prev;

	// remember the pointed status bit so a software clear is seen as a fall
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			pointed_prev <= 1'b0;
		else
			pointed_prev <= status[first_error_pointer];

	// capture while armed; rearm once the pointed bit is cleared
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			log_state <= PEMS_LOG_ARMED;
			first_error_pointer <= FEP_RESET;
			hdr_capture <= 1'b0;
		end
		else
		begin
			hdr_capture <= 1'b0;
			case (log_state)
				PEMS_LOG_ARMED:
					if (evt != 32'h00000000)
					begin
						log_state <= PEMS_LOG_LOCKED;
						first_error_pointer <= pems_first_bit(evt);
						hdr_capture <= 1'b1;
					end
				PEMS_LOG_LOCKED:
					if (pointed_prev && !status[first_error_pointer])
						log_state <= PEMS_LOG_ARMED;
				default:
					log_state <= PEMS_LOG_ARMED;
			endcase
		end

	capture_once_a: assert property (@(posedge ref_clk) disable iff (reset)
		log_state == PEMS_LOG_ARMED && evt != 32'h00000000 |=>
		hdr_capture && first_error_pointer == $past(pems_first_bit(evt)))
		else $error("first error not captured");
	locked_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
		log_state == PEMS_LOG_LOCKED && !(pointed_prev && !status[first_error_pointer])
		|=> !hdr_capture && $stable(first_error_pointer))
		else $error("locked log changed");
	rearm_seen_c: cover property (@(posedge ref_clk) disable iff (reset)
		log_state == PEMS_LOG_LOCKED ##1 log_state == PEMS_LOG_ARMED);
endmodule : pems_first_err

// ### hdl/pems_msg.sv
// Purpose: queues error message requests and hands them to the host bridge
// Assumes: msg_ready comes from host bridge logic on the same clock
// Notes: fatal beats non-fatal beats correctable when several wait
`timescale 1ns/10ps
module pems_msg
	import pems_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic link_reset,
	input wire logic fatal_req,
	input wire logic nonfatal_req,
	input wire logic cor_req,
	input wire logic msg_ready,
	output logic msg_valid,
	output logic [1:0] msg_code
);
	pems_tx_t state;
	logic pend_fatal, pend_nonfatal, pend_cor;
	logic sent;

	assign sent = state == PEMS_TX_SEND && msg_ready;

	// pending flags; a new request in the send cycle wins over the clear
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			pend_fatal <= 1'b0;
			pend_nonfatal <= 1'b0;
			pend_cor <= 1'b0;
		end
		else if (link_reset)
		begin
			pend_fatal <= 1'b0;
			pend_nonfatal <= 1'b0;
			pend_cor <= 1'b0;
		end
		else
		begin
			pend_fatal <= fatal_req | (pend_fatal & ~(sent && msg_code == PEMS_MSG_FATAL));
			pend_nonfatal <= nonfatal_req |
				(pend_nonfatal & ~(sent && msg_code == PEMS_MSG_NONFATAL));
			pend_cor <= cor_req | (pend_cor & ~(sent && msg_code == PEMS_MSG_COR));
		end

	// one message at a time, held until the host bridge takes it
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			state <= PEMS_TX_IDLE;
			msg_valid <= 1'b0;
			msg_code <= PEMS_MSG_COR;
		end
		else if (link_reset)
		begin
			state <= PEMS_TX_IDLE;
			msg_valid <= 1'b0;
		end
		else
			case (state)
				PEMS_TX_IDLE:
					if (pend_fatal | pend_nonfatal | pend_cor)
					begin
						state <= PEMS_TX_SEND;
						msg_valid <= 1'b1;
						msg_code <= pend_fatal ? PEMS_MSG_FATAL :
							pend_nonfatal ? PEMS_MSG_NONFATAL : PEMS_MSG_COR;
					end
				PEMS_TX_SEND:
					if (msg_ready)
					begin
						state <= PEMS_TX_IDLE;
						msg_valid <= 1'b0;
					end
				default:
					state <= PEMS_TX_IDLE;
			endcase

	fatal_first_a: assert property (@(posedge ref_clk) disable iff (reset)
		state == PEMS_TX_IDLE && !pend_fatal && !pend_nonfatal && !pend_cor && fatal_req &&
		!link_reset ##1 !link_reset |=> msg_valid && msg_code == PEMS_MSG_FATAL)
		else $error("fatal request not sent as fatal");
	nonfatal_code_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(msg_valid) && msg_code == PEMS_MSG_NONFATAL |-> $past(pend_nonfatal && !pend_fatal))
		else $error("non-fatal code without non-fatal request");
	msg_hold_a: assert property (@(posedge ref_clk) disable iff (reset || link_reset)
		msg_valid && !msg_ready |=> msg_valid && $stable(msg_code))
		else $error("message dropped before accept");
endmodule : pems_msg

// ### hdl/pems_err_mask_sev.sv
// Purpose: uncorrectable mask and severity, correctable status and mask registers
// Assumes: error events are one-cycle pulses from the link core on ref_clk
// Notes: reset is the power-good reset; link_reset spares sticky bits
// Notes on behaviour
// - masked uncorrectable error sends no message
// - masked uncorrectable error captures no header
// - masked uncorrectable error leaves pointer alone
// - status set pulse ignores the mask
// - sticky writable mask bits at implemented positions
// - mask bits 19 and 0 read zero
// - severity one means fatal, zero non-fatal
// - severity resets to 00030010h
// - severity 19 and 0 zero, rest sticky
// - replay timer expiry sets bit 12
// - replay counter wrap sets bit 8
// - bad link packet crc sets bit 7
// - bad transaction packet crc sets bit 6
// - receiver error sets bit 0
// - status bits clear only on written one
// - masked correctable error sends no message
// - sticky correctable mask bits reset to zero
// - pointer rearms when pointed status cleared
// - header log locked until status cleared
`timescale 1ns/10ps
module pems_err_mask_sev
	import pems_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic link_reset,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic [31:0] unc_err_evt,
	input wire logic [31:0] unc_status,
	input wire logic replay_timer_expired,
	input wire logic [1:0] replay_num,
	input wire logic bad_link_packet,
	input wire logic bad_transaction_packet,
	input wire logic receiver_error,
	output logic [31:0] unc_status_set,
	output logic hdr_capture,
	output logic [4:0] first_error_pointer,
	input wire logic msg_ready,
	output logic msg_valid,
	output logic [1:0] msg_code
);
	logic [31:0] uncorrectable_error_mask;
	logic [31:0] uncorrectable_error_severity;
	logic [31:0] correctable_error_status;
	logic [31:0] correctable_error_mask;
	logic [1:0] replay_num_prev;
	logic [31:0] unc_gated;
	logic fatal_req, nonfatal_req, cor_req;
	logic [31:0] lane, wr_bits, unc_hit, unc_open, cor_set;
	logic [31:0] next_cor_status;
	logic replay_wrap;
	logic wr_unc_mask, wr_unc_sev, wr_cor_sts, wr_cor_msk;

	// write decode and byte lanes
	assign wr_unc_mask = cfg_wr && cfg_addr == UNC_MASK_OFS;
	assign wr_unc_sev = cfg_wr && cfg_addr == UNC_SEV_OFS;
	assign wr_cor_sts = cfg_wr && cfg_addr == COR_STS_OFS;
	assign wr_cor_msk = cfg_wr && cfg_addr == COR_MSK_OFS;
	assign lane = pems_lane_mask(cfg_be);
	assign wr_bits = cfg_wdata & lane;

	// event vectors; unimplemented uncorrectable sources are dropped here
	always_comb
	begin
		unc_hit = unc_err_evt & UNC_IMPL_BITS;
		unc_open = unc_hit & ~uncorrectable_error_mask;
		replay_wrap = replay_num == REPLAY_NUM_FIRST && replay_num_prev == REPLAY_NUM_LAST;
		cor_set = 32'h00000000;
		cor_set[COR_REPLAY_TIMEOUT_BIT] = replay_timer_expired;
		cor_set[COR_REPLAY_WRAP_BIT] = replay_wrap;
		cor_set[COR_BAD_LINK_BIT] = bad_link_packet;
		cor_set[COR_BAD_TRANS_BIT] = bad_transaction_packet;
		cor_set[COR_RECEIVER_BIT] = receiver_error;
	end

	// write one to clear; an event in the same cycle keeps the bit set
	always_comb
	begin
		next_cor_status = correctable_error_status;
		if (wr_cor_sts)
			next_cor_status = correctable_error_status & ~wr_bits;
		next_cor_status = (next_cor_status | cor_set) & COR_IMPL_BITS;
	end

	// sticky uncorrectable mask; only power-good reset clears it
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			uncorrectable_error_mask <= UNC_MASK_RESET;
		else if (wr_unc_mask)
			uncorrectable_error_mask <= ((uncorrectable_error_mask & ~lane) | wr_bits) &
				UNC_IMPL_BITS;

	// sticky severity; reserved and not applicable bits forced to zero
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			uncorrectable_error_severity <= UNC_SEV_RESET;
		else if (wr_unc_sev)
			uncorrectable_error_severity <= ((uncorrectable_error_severity & ~lane) |
				wr_bits) & UNC_IMPL_BITS;

	// sticky correctable mask
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			correctable_error_mask <= COR_MSK_RESET;
		else if (wr_cor_msk)
			correctable_error_mask <= ((correctable_error_mask & ~lane) | wr_bits) &
				COR_IMPL_BITS;

	// sticky correctable status
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			correctable_error_status <= COR_STS_RESET;
		else
			correctable_error_status <= next_cor_status;

	// replay counter history; not sticky, so a link reset restarts it
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			replay_num_prev <= REPLAY_NUM_FIRST;
		else if (link_reset)
			replay_num_prev <= REPLAY_NUM_FIRST;
		else
			replay_num_prev <= replay_num;

	// status set pulses go out whatever the mask says
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			unc_status_set <= 32'h00000000;
		else
			unc_status_set <= unc_hit;

	// unmasked sources for the first error and header log tracker
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
			unc_gated <= 32'h00000000;
		else if (link_reset)
			unc_gated <= 32'h00000000;
		else
			unc_gated <= unc_open;

	// message requests; severity is read at the moment of the error
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			fatal_req <= 1'b0;
			nonfatal_req <= 1'b0;
			cor_req <= 1'b0;
		end
		else if (link_reset)
		begin
			fatal_req <= 1'b0;
			nonfatal_req <= 1'b0;
			cor_req <= 1'b0;
		end
		else
		begin
			fatal_req <= |(unc_open & uncorrectable_error_severity);
			nonfatal_req <= |(unc_open & ~uncorrectable_error_severity);
			cor_req <= |(cor_set & ~correctable_error_mask);
		end

	// read data one cycle after the strobe; unmapped offsets answer zero
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd)
				case (cfg_addr)
					UNC_MASK_OFS: cfg_rdata <= uncorrectable_error_mask;
					UNC_SEV_OFS: cfg_rdata <= uncorrectable_error_severity;
					COR_STS_OFS: cfg_rdata <= correctable_error_status;
					COR_MSK_OFS: cfg_rdata <= correctable_error_mask;
					default: cfg_rdata <= 32'h00000000;
				endcase
		end

	// pointer and log lock live beside the status block they watch
	pems_first_err u_first_err (
		.ref_clk(ref_clk),
		.reset(reset),
		.evt(unc_gated),
		.status(unc_status),
		.first_error_pointer(first_error_pointer),
		.hdr_capture(hdr_capture)
	);

	// message queue toward the host bridge
	pems_msg u_msg (
		.ref_clk(ref_clk),
		.reset(reset),
		.link_reset(link_reset),
		.fatal_req(fatal_req),
		.nonfatal_req(nonfatal_req),
		.cor_req(cor_req),
		.msg_ready(msg_ready),
		.msg_valid(msg_valid),
		.msg_code(msg_code)
	);

	default clocking pems_cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	masked_no_msg_a: assert property (unc_hit != 32'h00000000 && unc_open == 32'h00000000 &&
		!link_reset |=> !fatal_req && !nonfatal_req)
		else $error("masked uncorrectable error raised a message");
	masked_no_log_a: assert property (unc_open == 32'h00000000 && !link_reset |->
		##2 !hdr_capture)
		else $error("masked error captured a header");
	masked_fep_a: assert property (unc_open == 32'h00000000 |->
		##2 $stable(first_error_pointer))
		else $error("masked error moved the pointer");
	status_set_a: assert property (1'b1 |=> unc_status_set ==
		$past(unc_err_evt & UNC_IMPL_BITS))
		else $error("status set pulse wrong");
	reserved_zero_a: assert property ((uncorrectable_error_mask & ~UNC_IMPL_BITS) == 0 &&
		(uncorrectable_error_severity & ~UNC_IMPL_BITS) == 0 &&
		(correctable_error_status & ~COR_IMPL_BITS) == 0 &&
		(correctable_error_mask & ~COR_IMPL_BITS) == 0)
		else $error("reserved bit set");
	sev_reset_a: assert property ($past(reset) |-> uncorrectable_error_severity ==
		UNC_SEV_RESET && correctable_error_mask == COR_MSK_RESET)
		else $error("severity reset value wrong");
	mask_write_a: assert property (wr_unc_mask && cfg_be == 4'hf |=>
		uncorrectable_error_mask == ($past(cfg_wdata) & UNC_IMPL_BITS))
		else $error("mask write not stored");
	timeout_set_a: assert property (replay_timer_expired |=>
		correctable_error_status[COR_REPLAY_TIMEOUT_BIT])
		else $error("replay timeout not flagged");
	wrap_set_a: assert property (replay_num == REPLAY_NUM_LAST && !link_reset ##1
		replay_num == REPLAY_NUM_FIRST |=> correctable_error_status[COR_REPLAY_WRAP_BIT])
		else $error("replay wrap not flagged");
	crc_rx_set_a: assert property (bad_link_packet || bad_transaction_packet ||
		receiver_error |=> correctable_error_status[COR_BAD_LINK_BIT] >=
		$past(bad_link_packet) && correctable_error_status[COR_BAD_TRANS_BIT] >=
		$past(bad_transaction_packet) && correctable_error_status[COR_RECEIVER_BIT] >=
		$past(receiver_error))
		else $error("receive error not flagged");
	cor_w1c_a: assert property (wr_cor_sts && cor_set == 32'h00000000 |=>
		correctable_error_status == ($past(correctable_error_status) & ~$past(wr_bits)))
		else $error("write one to clear wrong");
	cor_hold_a: assert property (!wr_cor_sts && cor_set == 32'h00000000 |=>
		$stable(correctable_error_status))
		else $error("status changed without cause");
	cor_masked_a: assert property ((cor_set & ~correctable_error_mask) == 32'h00000000 |=>
		!cor_req)
		else $error("masked correctable error raised a message");
	sticky_link_a: assert property (link_reset && !cfg_wr |=>
		$stable(uncorrectable_error_mask) && $stable(uncorrectable_error_severity) &&
		$stable(correctable_error_mask))
		else $error("sticky bit lost on link reset");

	fatal_msg_c: cover property (msg_valid && msg_ready && msg_code == PEMS_MSG_FATAL);
	cor_msg_c: cover property (msg_valid && msg_ready && msg_code == PEMS_MSG_COR);
	wrap_seen_c: cover property (replay_wrap);
	masked_hit_c: cover property (unc_hit != 32'h00000000 && unc_open == 32'h00000000);
endmodule : pems_err_mask_sev

// ### verification/pems_host_model.sv
// Purpose: host bridge end of the error message path, accepts and records messages
// Assumes: msg_valid and msg_code hold until the edge that sees msg_ready high
// Notes: hold_cycles stretches the wait before ready, so the host can act slow
`timescale 1ns/10ps
module pems_host_model
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic msg_valid,
	input wire logic [1:0] msg_code,
	input wire logic [3:0] hold_cycles,
	output logic msg_ready,
	output int got_count,
	output logic [1:0] last_code
);
	logic [3:0] wait_cnt;

	// ready only after hold_cycles of valid; dropped at the accepting edge
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			msg_ready <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (msg_ready && msg_valid)
		begin
			msg_ready <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (msg_valid && wait_cnt >= hold_cycles)
			msg_ready <= 1'b1;
		else if (msg_valid)
			wait_cnt <= wait_cnt + 4'h1;
	end

	// record what was accepted, at the same edge the handshake completes
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			got_count <= 0;
			last_code <= 2'h0;
		end
		else if (msg_ready && msg_valid)
		begin
			got_count <= got_count + 1;
			last_code <= msg_code;
		end
	end
endmodule : pems_host_model

// ### verification/pems_tb.sv
// Purpose: self-checking bench for the error mask and severity bank
// Assumes: the outside uncorrectable status is modelled here from unc_status_set
// Notes: each scenario is its own task; every wait is bounded
`timescale 1ns/10ps
module tb
	import pems_pkg::*;
;
	logic ref_clk, reset, link_reset, cfg_wr, cfg_rd, cfg_rvalid;
	logic [11:0] cfg_addr;
	logic [3:0] cfg_be, hold_cycles;
	logic [31:0] cfg_wdata, cfg_rdata, unc_err_evt, unc_status, unc_status_set, unc_clear;
	logic replay_timer_expired, bad_link_packet, bad_transaction_packet, receiver_error;
	logic [1:0] replay_num, msg_code, last_code;
	logic hdr_capture, msg_ready, msg_valid;
	logic [4:0] first_error_pointer;
	int got_count, fails, n_checks, n_msg;

	pems_err_mask_sev uut (.ref_clk(ref_clk), .reset(reset), .link_reset(link_reset),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.unc_err_evt(unc_err_evt), .unc_status(unc_status),
		.replay_timer_expired(replay_timer_expired), .replay_num(replay_num),
		.bad_link_packet(bad_link_packet), .bad_transaction_packet(bad_transaction_packet),
		.receiver_error(receiver_error), .unc_status_set(unc_status_set),
		.hdr_capture(hdr_capture), .first_error_pointer(first_error_pointer),
		.msg_ready(msg_ready), .msg_valid(msg_valid), .msg_code(msg_code));
	pems_host_model host (.ref_clk(ref_clk), .reset(reset), .msg_valid(msg_valid),
		.msg_code(msg_code), .hold_cycles(hold_cycles), .msg_ready(msg_ready),
		.got_count(got_count), .last_code(last_code));

	// outside status block: set by the pulse vector, cleared by software write-one
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			unc_status <= 32'h0;
		else
			unc_status <= (unc_status | unc_status_set) & ~unc_clear;
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] data);
		@(posedge ref_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= addr;
		cfg_be <= be;
		cfg_wdata <= data;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
	endtask : wr

	// answer lands at the taking edge itself and is checked 1 ns after it
	task automatic rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
		@(posedge ref_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= addr;
		@(posedge ref_clk);
		cfg_rd <= 1'b0;
		#1;
		chk({what, " valid"}, 32'h1, {31'h0, cfg_rvalid});
		chk(what, exp, cfg_rdata);
	endtask : rd

	task automatic pulse(input logic [31:0] unc, input logic [3:0] cor, output logic [31:0] s,
		output logic c);
		@(posedge ref_clk);
		unc_err_evt <= unc;
		{replay_timer_expired, bad_link_packet, bad_transaction_packet, receiver_error} <= cor;
		@(posedge ref_clk);
		unc_err_evt <= 32'h0;
		{replay_timer_expired, bad_link_packet, bad_transaction_packet, receiver_error} <= 4'h0;
		#1;
		s = unc_status_set;
		@(posedge ref_clk);
		#1;
		c = hdr_capture;
	endtask : pulse

	// bounded wait for the host to have seen the expected number of messages
	task automatic msgs(input logic send, input logic [1:0] code);
		int k;
		if (send)
			n_msg++;
		repeat (8) @(posedge ref_clk);
		for (k = 0; k < 20 && got_count != n_msg; k++)
			@(posedge ref_clk);
		chk("message count", 32'(n_msg), 32'(got_count));
		if (send)
			chk("message code", {30'h0, code}, {30'h0, last_code});
		// any count still off after the bound, short or over, ends the run as a hang
		if (got_count != n_msg)
			complete_run();
	endtask : msgs

	task automatic unc_case(input int b, input logic cap, input logic [4:0] fep,
		input logic send, input logic [1:0] code);
		logic [31:0] s;
		logic c;
		pulse(32'h1 << b, 4'h0, s, c);
		chk("status set", UNC_IMPL_BITS & (32'h1 << b), s);
		chk("header capture", {31'h0, cap}, {31'h0, c});
		chk("first error pointer", {27'h0, fep}, {27'h0, first_error_pointer});
		msgs(send, code);
	endtask : unc_case

	task automatic unc_clr(input int b);
		@(posedge ref_clk);
		unc_clear <= 32'h1 << b;
		@(posedge ref_clk);
		unc_clear <= 32'h0;
		repeat (2) @(posedge ref_clk);
	endtask : unc_clr

	task automatic s_reset();
		rd("unc mask", UNC_MASK_OFS, 32'h00000000);
		rd("unc severity", UNC_SEV_OFS, 32'h00030010);
		rd("cor status", COR_STS_OFS, 32'h00000000);
		rd("cor mask", COR_MSK_OFS, 32'h00000000);
		wr(12'h118, 4'hf, 32'hffffffff);
		rd("unmapped", 12'h118, 32'h00000000);
	endtask : s_reset

	// first capture locks the log; a later error only sends its message
	task automatic s_unc();
		unc_case(18, 1'b1, 5'h12, 1'b1, PEMS_MSG_NONFATAL);
		unc_case(17, 1'b0, 5'h12, 1'b1, PEMS_MSG_FATAL);
		unc_clr(18);
		unc_case(4, 1'b1, 5'h04, 1'b1, PEMS_MSG_FATAL);
		unc_clr(17);
		unc_clr(4);
	endtask : s_unc

	task automatic s_regs();
		wr(UNC_MASK_OFS, 4'hf, 32'hffffffff);
		rd("unc mask ones", UNC_MASK_OFS, 32'h0017f010);
		wr(UNC_SEV_OFS, 4'hf, 32'hffffffff);
		rd("unc severity ones", UNC_SEV_OFS, 32'h0017f010);
		wr(UNC_SEV_OFS, 4'h1, 32'h00000000);
		rd("unc severity lane", UNC_SEV_OFS, 32'h0017f000);
		wr(COR_MSK_OFS, 4'hf, 32'hffffffff);
		rd("cor mask ones", COR_MSK_OFS, 32'h000011c1);
		@(posedge ref_clk);
		link_reset <= 1'b1;
		@(posedge ref_clk);
		link_reset <= 1'b0;
		rd("unc mask kept", UNC_MASK_OFS, 32'h0017f010);
		rd("unc severity kept", UNC_SEV_OFS, 32'h0017f000);
		rd("cor mask kept", COR_MSK_OFS, 32'h000011c1);
		wr(UNC_MASK_OFS, 4'hf, 32'h00000000);
		wr(UNC_SEV_OFS, 4'hf, 32'h00030010);
		wr(COR_MSK_OFS, 4'hf, 32'h00000000);
	endtask : s_regs

	task automatic s_masked();
		wr(UNC_MASK_OFS, 4'hf, 32'h00100000);
		unc_case(20, 1'b0, 5'h04, 1'b0, 2'h0);
		unc_case(19, 1'b0, 5'h04, 1'b0, 2'h0);
		wr(UNC_MASK_OFS, 4'hf, 32'h00000000);
		wr(UNC_SEV_OFS, 4'hf, 32'h00001000);
		unc_case(12, 1'b1, 5'h0c, 1'b1, PEMS_MSG_FATAL);
	endtask : s_masked

	// slow host here, so messages wait on the handshake
	task automatic s_cor();
		int pos [4] = '{12, 7, 6, 0};
		logic [31:0] acc;
		logic [31:0] s;
		logic c;
		acc = 32'h0;
		@(posedge ref_clk);
		hold_cycles <= 4'h5;
		for (int i = 0; i < 4; i++)
		begin
			pulse(32'h0, 4'h8 >> i, s, c);
			acc = acc | (32'h1 << pos[i]);
			msgs(1'b1, PEMS_MSG_COR);
			rd("cor status", COR_STS_OFS, acc);
		end
		@(posedge ref_clk);
		replay_num <= 2'h2;
		@(posedge ref_clk);
		replay_num <= 2'h3;
		@(posedge ref_clk);
		replay_num <= 2'h0;
		acc = acc | 32'h00000100;
		msgs(1'b1, PEMS_MSG_COR);
		rd("cor status wrap", COR_STS_OFS, acc);
		wr(COR_STS_OFS, 4'hf, 32'h00000000);
		rd("cor status zero write", COR_STS_OFS, acc);
		wr(COR_STS_OFS, 4'hf, 32'hffffffff);
		rd("cor status cleared", COR_STS_OFS, 32'h00000000);
		wr(COR_MSK_OFS, 4'hf, 32'h00000080);
		pulse(32'h0, 4'h4, s, c);
		msgs(1'b0, 2'h0);
		rd("cor status masked", COR_STS_OFS, 32'h00000080);
	endtask : s_cor

	initial
	begin
		reset = 1'b1;
		link_reset = 1'b0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 12'h000;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		unc_err_evt = 32'h0;
		unc_clear = 32'h0;
		replay_timer_expired = 1'b0;
		replay_num = 2'h0;
		bad_link_packet = 1'b0;
		bad_transaction_packet = 1'b0;
		receiver_error = 1'b0;
		hold_cycles = 4'h0;
		fails = 0;
		n_checks = 0;
		n_msg = 0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		s_reset();
		s_unc();
		s_regs();
		s_masked();
		s_cor();
		complete_run();
	end
endmodule : tb
